/* pmt_map.svh */
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

// ==========================================================
// register byte offsets
`define PMT_OFF_TICK_COUNT 12'h000
`define PMT_OFF_PERIOD_LIMIT 12'h004
`define PMT_OFF_TIMER_CONTROL 12'h008
`define PMT_OFF_IRQ_REQUEST 12'h00c
`define PMT_OFF_IRQ_ENABLE 12'h010
`define PMT_OFF_IRQ_PRIORITY 12'h014

// ==========================================================
// reset values
`define PMT_RST_TICK_COUNT 8'h00
`define PMT_RST_PERIOD_LIMIT 8'hff
`define PMT_RST_TIMER_CONTROL 7'h00

// ==========================================================
// field positions
`define PMT_CTL_POST_HI 6
`define PMT_CTL_POST_LO 3
`define PMT_CTL_ON_BIT 2
`define PMT_CTL_PRE_HI 1
`define PMT_CTL_PRE_LO 0
`define PMT_IRQ_MATCH_BIT 3

// ==========================================================
// timing counts
`define PMT_INSTR_DIV 2'h3
`define PMT_PRE_DIV4_LAST 4'h3
`define PMT_PRE_DIV16_LAST 4'hf

`endif

/* pmt_pkg.sv */
package pmt_pkg;

  typedef enum logic [1:0] {
    PMT_PRE_1 = 2'h0,
    PMT_PRE_4 = 2'h1,
    PMT_PRE_16A = 2'h2,
    PMT_PRE_16B = 2'h3
  } pmt_pre_e;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic counter_on;
    pmt_pre_e prescale_select;
  } pmt_ctl_s;

  typedef struct packed {
    logic [7:0] tick_count;
    logic [7:0] period_limit;
    pmt_ctl_s ctl;
    logic [1:0] instr_cnt;
    logic [3:0] pre_cnt;
    logic [3:0] post_cnt;
    logic match_irq_flag;
    logic match_irq_enable;
    logic match_irq_priority;
    logic pwm_base_pulse;
    logic irq_out;
    logic [31:0] prdata;
    logic pready;
  } pmt_state_s;

endpackage

/* pmt_pwm_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// pwm side: counts time base pulses, keeps last spacing
module pmt_pwm_sink (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // time base
  input wire logic pwm_base_pulse,
  // observations
  output logic [15:0] n_pulse,
  output logic [15:0] gap
);
  logic [15:0] run_ff;
  // pulse used as period base only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_pulse <= 16'h0;
      gap <= 16'h0;
      run_ff <= 16'h0;
    end else begin
      run_ff <= pwm_base_pulse ? 16'h1 : run_ff + 16'h1;
      if (pwm_base_pulse) begin
        n_pulse <= n_pulse + 16'h1;
        gap <= run_ff;
      end
    end
  end
endmodule // pmt_pwm_sink
`default_nettype wire

/* pmt_timer.sv */
// How it works
// - instruction clock through 1, 4, 16 prescaler
// - count to period_limit then wrap zero
// - period_limit resets to ff, read/write
// - match feeds postscaler which sets flag
// - postscale ratio is field value plus one
// - counter writes, control writes clear scalers
// - control write keeps tick_count unchanged
// - tick_count readable, writable, resets zero
// - counts only while counter_on is set
// - control bit7 zero, fields reset zero
// - unscaled match pulse is PWM base only
// - flag at bit3 with enable, priority
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module pmt_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture_compare_unit side
  output logic pwm_base_pulse,
  // interrupt request to the core
  output logic match_irq,
  output logic match_irq_high_prio
);

  pmt_pkg::pmt_state_s state_ff;
  pmt_pkg::pmt_state_s nxt_state;
  logic slverr_ff;
  logic nxt_slverr;

  // ==========================================================
  // helpers
  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `PMT_OFF_TICK_COUNT) || (a == `PMT_OFF_PERIOD_LIMIT) ||
                 (a == `PMT_OFF_TIMER_CONTROL) || (a == `PMT_OFF_IRQ_REQUEST) ||
                 (a == `PMT_OFF_IRQ_ENABLE) || (a == `PMT_OFF_IRQ_PRIORITY);
  endfunction

  function automatic logic [3:0] pre_last(input pmt_pkg::pmt_pre_e sel);
    unique case (sel)
      pmt_pkg::PMT_PRE_1: pre_last = 4'h0;
      pmt_pkg::PMT_PRE_4: pre_last = `PMT_PRE_DIV4_LAST;
      pmt_pkg::PMT_PRE_16A,
      pmt_pkg::PMT_PRE_16B: pre_last = `PMT_PRE_DIV16_LAST;
    endcase
  endfunction

  // ==========================================================
  // next state
  logic acc;
  logic wr;
  logic rd;
  logic instr_tick;
  logic pre_tick;
  logic match;
  logic post_done;
  logic scaler_clr;
  logic flag_clr;
  logic [31:0] rdat;

  always_comb begin
    nxt_state = state_ff;
    nxt_slverr = 1'b0;
    acc = psel && penable && !state_ff.pready;
    wr = acc && pwrite && pstrb[0];
    rd = acc && !pwrite;
    scaler_clr = 1'b0;
    flag_clr = 1'b0;
    rdat = 32'h0000_0000;
    nxt_state.pready = acc;
    nxt_state.pwm_base_pulse = 1'b0;

    // instruction clock is pclk divided by four, prescaled after it
    instr_tick = 1'b0;
    pre_tick = 1'b0;
    match = 1'b0;
    post_done = 1'b0;
    if (state_ff.ctl.counter_on) begin
      nxt_state.instr_cnt = state_ff.instr_cnt + 2'h1;
      instr_tick = (state_ff.instr_cnt == `PMT_INSTR_DIV);
    end
    if (instr_tick) begin
      if (state_ff.pre_cnt >= pre_last(state_ff.ctl.prescale_select)) begin
        nxt_state.pre_cnt = 4'h0;
        pre_tick = 1'b1;
      end else begin
        nxt_state.pre_cnt = state_ff.pre_cnt + 4'h1;
      end
    end
    // wrap on the increment after a match
    if (pre_tick) begin
      if (state_ff.tick_count == state_ff.period_limit) begin
        nxt_state.tick_count = 8'h00;
        match = 1'b1;
      end else begin
        nxt_state.tick_count = state_ff.tick_count + 8'h01;
      end
    end
    nxt_state.pwm_base_pulse = match;
    if (match) begin
      if (state_ff.post_cnt >= state_ff.ctl.postscale_select) begin
        nxt_state.post_cnt = 4'h0;
        post_done = 1'b1;
      end else begin
        nxt_state.post_cnt = state_ff.post_cnt + 4'h1;
      end
    end

    // ==========================================================
    // register writes
    if (wr) begin
      unique case (paddr)
        `PMT_OFF_TICK_COUNT: begin
          nxt_state.tick_count = pwdata[7:0];
          scaler_clr = 1'b1;
        end
        `PMT_OFF_PERIOD_LIMIT: nxt_state.period_limit = pwdata[7:0];
        `PMT_OFF_TIMER_CONTROL: begin
          nxt_state.ctl = pmt_pkg::pmt_ctl_s'(pwdata[6:0]);
          scaler_clr = 1'b1;
        end
        `PMT_OFF_IRQ_REQUEST: flag_clr = !pwdata[`PMT_IRQ_MATCH_BIT];
        `PMT_OFF_IRQ_ENABLE: nxt_state.match_irq_enable = pwdata[`PMT_IRQ_MATCH_BIT];
        `PMT_OFF_IRQ_PRIORITY: nxt_state.match_irq_priority = pwdata[`PMT_IRQ_MATCH_BIT];
        default: ;
      endcase
    end
    // clear scalers; the divide-by-four phase restarts too
    if (scaler_clr) begin
      nxt_state.pre_cnt = 4'h0;
      nxt_state.post_cnt = 4'h0;
      nxt_state.instr_cnt = 2'h0;
    end

    // flag held until software writes zero
    if (flag_clr) begin
      nxt_state.match_irq_flag = 1'b0;
    end
    // set wins over a same-cycle clear
    if (post_done && !scaler_clr) begin
      nxt_state.match_irq_flag = 1'b1;
    end
    nxt_state.irq_out = nxt_state.match_irq_flag && nxt_state.match_irq_enable;

    // ==========================================================
    // register reads
    if (rd) begin
      unique case (paddr)
        `PMT_OFF_TICK_COUNT: rdat = {24'h0, state_ff.tick_count};
        `PMT_OFF_PERIOD_LIMIT: rdat = {24'h0, state_ff.period_limit};
        `PMT_OFF_TIMER_CONTROL: rdat = {25'h0, state_ff.ctl};
        `PMT_OFF_IRQ_REQUEST: rdat = {28'h0, state_ff.match_irq_flag, 3'h0};
        `PMT_OFF_IRQ_ENABLE: rdat = {28'h0, state_ff.match_irq_enable, 3'h0};
        `PMT_OFF_IRQ_PRIORITY: rdat = {28'h0, state_ff.match_irq_priority, 3'h0};
        default: rdat = 32'h0000_0000;
      endcase
    end
    nxt_state.prdata = rdat;
    nxt_slverr = acc && !addr_known(paddr);
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff.tick_count <= `PMT_RST_TICK_COUNT;
      state_ff.period_limit <= `PMT_RST_PERIOD_LIMIT;
      state_ff.ctl <= pmt_pkg::pmt_ctl_s'(`PMT_RST_TIMER_CONTROL);
      state_ff.instr_cnt <= 2'h0;
      state_ff.pre_cnt <= 4'h0;
      state_ff.post_cnt <= 4'h0;
      state_ff.match_irq_flag <= 1'b0;
      state_ff.match_irq_enable <= 1'b0;
      // lowest-risk default: high priority, as on power-up
      state_ff.match_irq_priority <= 1'b1;
      state_ff.pwm_base_pulse <= 1'b0;
      state_ff.irq_out <= 1'b0;
      state_ff.prdata <= 32'h0000_0000;
      state_ff.pready <= 1'b0;
      slverr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      slverr_ff <= nxt_slverr;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = slverr_ff;
  assign pwm_base_pulse = state_ff.pwm_base_pulse;
  assign match_irq = state_ff.irq_out;
  assign match_irq_high_prio = state_ff.match_irq_priority;

endmodule // pmt_timer

`default_nettype wire

/* pmt_timer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// bus answer and time base checks
module pmt_timer_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // time base
  input wire logic pwm_base_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  // fastest step is four clocks, so a pulse is never closer
  sequence s_gap;
    !pwm_base_pulse [*3];
  endsequence
  rdy_wait_a: assert property (s_acc |=> pready)
    else $error("late pready");
  rdy_once_a: assert property (pready |=> !pready)
    else $error("long pready");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read not zero");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  ctl_bit7_a: assert property (pready && !pwrite && paddr == 12'h008 |-> !prdata[7])
    else $error("control bit7 set");
  wr_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write data not zero");
  pwm_gap_a: assert property (pwm_base_pulse |=> s_gap)
    else $error("time base pulse too close");
endmodule // pmt_timer_chk
bind pmt_timer pmt_timer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pwm_base_pulse);
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic e;} pmt_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic pwm_base_pulse, match_irq, match_irq_high_prio;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] n_pulse, gap;
  logic [3:0] post [3] = '{4'h0, 4'h1, 4'hf};
  int mismatches, n_tests, cyc, n0;
  pmt_row_s rows [13] = '{'{1'h0, 12'h000, 8'h00, 1'h0}, '{1'h0, 12'h004, 8'hff, 1'h0},
    '{1'h1, 12'h014, 8'h00, 1'h0}, '{1'h0, 12'h014, 8'h00, 1'h0},
    '{1'h0, 12'h00c, 8'h00, 1'h0},
    '{1'h0, 12'h008, 8'h00, 1'h0}, '{1'h1, 12'h004, 8'h5a, 1'h0},
    '{1'h0, 12'h004, 8'h5a, 1'h0}, '{1'h1, 12'h000, 8'h33, 1'h0},
    '{1'h1, 12'h008, 8'hfb, 1'h0}, '{1'h0, 12'h008, 8'h7b, 1'h0},
    '{1'h0, 12'h000, 8'h33, 1'h0}, '{1'h0, 12'h018, 8'h00, 1'h1}};
  pmt_timer u_pmt_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .pwm_base_pulse, .match_irq, .match_irq_high_prio);
  pmt_pwm_sink u_pmt_pwm_sink (.pclk, .presetn, .pwm_base_pulse, .n_pulse, .gap);
  task automatic test_done;
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================
  // hang guard, well above the longest run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    check("prio", 32'h1, {31'h0, match_irq_high_prio});
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
      if (!rows[i].w) check("row", {24'h0, rows[i].d}, rd);
      check("err", {31'h0, rows[i].e}, {31'h0, err});
    end
    check("prio_wr", 32'h0, {31'h0, match_irq_high_prio});
    apb(1'h1, 12'h004, 32'h2);
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, 12'h008, {29'h0, 1'h1, c[1:0]});
      n0 = n_pulse;
      while (n_pulse < n0 + 3) @(posedge pclk);
      check("gap", 32'(12 * (c == 0 ? 1 : (c == 1 ? 4 : 16))), {16'h0, gap});
    end
    apb(1'h1, 12'h004, 32'h1);
    apb(1'h1, 12'h010, 32'h8);
    foreach (post[k]) begin
      apb(1'h1, 12'h008, 32'h0);
      apb(1'h1, 12'h00c, 32'h0);
      apb(1'h1, 12'h000, 32'h0);
      n0 = n_pulse;
      apb(1'h1, 12'h008, {25'h0, post[k], 3'h4});
      while (match_irq !== 1'h1) @(posedge pclk);
      repeat (2) @(posedge pclk);
      check("post", 32'(post[k]) + 32'h1, 32'(n_pulse) - 32'(n0));
    end
    apb(1'h1, 12'h008, 32'h0);
    repeat (8) @(posedge pclk);
    check("sticky", 32'h1, {31'h0, match_irq});
    apb(1'h0, 12'h00c, 32'h0);
    check("flag_rd", 32'h8, rd);
    apb(1'h1, 12'h010, 32'h0);
    repeat (2) @(posedge pclk);
    check("mask", 32'h0, {31'h0, match_irq});
    // a write without the low byte strobe must leave the period alone
    pstrb <= 4'he;
    apb(1'h1, 12'h004, 32'h77);
    pstrb <= 4'hf;
    apb(1'h0, 12'h004, 32'h0);
    check("strb", 32'h1, rd);
    apb(1'h1, 12'h008, 32'h4);
    repeat (30) @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    check("rst_pwm", 32'h0, {31'h0, pwm_base_pulse});
    presetn <= 1'h1;
    apb(1'h0, 12'h004, 32'h0);
    check("rst_per", 32'hff, rd);
    apb(1'h0, 12'h000, 32'h0);
    check("rst_cnt", 32'h0, rd);
    test_done();
  end
endmodule // tb
`default_nettype wire
